/* rtl/ast_pkg.sv */
package ast_pkg;

  // Bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [4:0] OFS_CTRL_ONE = 5'h00;
  localparam logic [4:0] OFS_CTRL_TWO = 5'h04;
  localparam logic [4:0] OFS_STATUS = 5'h08;
  localparam logic [4:0] OFS_DATA = 5'h0c;

  // Reset values
  localparam logic [7:0] CTRL_ONE_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h0c;

  // Baud select codes and divisors (receiver clock = clk / divisor)
  localparam logic [2:0] BAUD_TIMER = 3'h6;
  localparam logic [8:0] DIV_SEL0 = 9'h00d;
  localparam logic [8:0] DIV_SEL1 = 9'h01a;
  localparam logic [8:0] DIV_SEL2 = 9'h034;
  localparam logic [8:0] DIV_SEL3 = 9'h068;
  localparam logic [8:0] DIV_SEL4 = 9'h0d0;
  localparam logic [8:0] DIV_SEL5 = 9'h1a0;
  localparam logic [8:0] DIV_SEL7 = 9'h060;

  // Sample ticks within one bit (sixteen per bit)
  localparam logic [3:0] RT_LAST = 4'hf;
  localparam logic [3:0] RT_SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] RT_SAMPLE_LAST = 4'h9;

  // Frame shape
  localparam logic [2:0] DATA_LAST_IDX = 3'h7;
  localparam logic [3:0] FRAME_BASE_BITS = 4'ha;

  // Control register one layout
  typedef struct packed {
    logic tx_enable_bit;
    logic rx_enable_bit;
    logic tx_stop_length;
    logic parity_even_bit;
    logic parity_enable_bit;
    logic [2:0] baud_select;
  } ast_ctrl_s;

  // Status register layout
  typedef struct packed {
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic rx_buffer_full_flag;
    logic tx_done_flag;
    logic tx_buffer_empty_flag;
    logic [1:0] spare;
  } ast_status_s;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_PARITY = 3'h3,
    RX_STOP_ONE = 3'h4,
    RX_STOP_TWO = 3'h5
  } ast_rx_state_e;

endpackage

/* rtl/ast_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ast_pin_sync (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic pin,
  output logic level
);
  logic stage_one;
  logic stage_two;
  logic stage_three;

  // Three-stage chain; line idles high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_one <= 1'b1;
      stage_two <= 1'b1;
      stage_three <= 1'b1;
    end else begin
      stage_one <= pin;
      stage_two <= stage_one;
      stage_three <= stage_two;
    end
  end

  // Accept a new level once the last two stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level <= 1'b1;
    end else if (stage_two == stage_three) begin
      level <= stage_three;
    end
  end
endmodule
`default_nettype wire

/* rtl/ast_uart.sv */
`timescale 1ns/1ps
`default_nettype none
// Contract
// (RULE1) Software enables transmit, reads status, sees buffer empty, then writes data
// (RULE2) Data write clears buffer-empty, loads shift register, shifts out on pin
// (RULE3) Frame: low start, data, optional parity, one or two high stops
// (RULE4) Transmit start sets buffer-empty and raises the shared interrupt
// (RULE5) Transmit pin held high when disabled or nothing written yet; a frame already started still runs to its end after disable
// (RULE6) Data write without prior status read leaves flag set, no transmit
// (RULE7) After stop bits, data only goes to buffer, full flag set, interrupt
// (RULE8) New character while buffer full sets overrun, new data discarded
// (RULE9) Receive disable takes effect only when the current character ends
// (RULE10) Received parity mismatch sets parity error flag
// (RULE11) Stop bit sampled low sets framing error flag
// (RULE12) Status read then buffer read clears the four receive flags
// (RULE13) While overrun is set no further characters are accepted
// (RULE14) Overrun set after the status read survives the buffer read
// (RULE15) Transmit end set when sent and buffer empty, cleared on new start
// (RULE16) Parity enable and odd/even type shared by both directions
// (RULE17) Baud select sets the rate for both directions
// (RULE18) Receiver clock is clk over 13..416, timer tick, or over 96
// (RULE19) Bit rate is receiver clock over sixteen
// (RULE20) Bits sampled at ticks seven, eight, nine with majority vote
// (RULE21) Least significant bit first, line high between frames
module ast_uart (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ast_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [ast_pkg::DATA_W-1:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [ast_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  input wire logic timer_tick,
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_txrx_irq
);
  import ast_pkg::*;

  ast_ctrl_s ctrl;
  ast_status_s status_view;
  ast_rx_state_e rx_state;
  logic rx_stop_length;
  logic tx_buffer_empty_flag, tx_done_flag, rx_buffer_full_flag;
  logic parity_error_flag, framing_error_flag, overrun_flag;
  logic [7:0] rx_data_buffer, tx_hold, rx_shift;
  logic req, bus_take, wr_ctrl_one, wr_ctrl_two, wr_data, rd_status, rd_data;
  logic [31:0] rd_mux;
  logic tx_armed, rx_armed, ovr_seen, tx_wr_ok, rx_clear;
  logic [8:0] div_max, baud_cnt;
  logic rt_tick;
  logic tx_busy, tx_pending, tx_load, tx_bit_end, tx_last, tx_par;
  logic [11:0] tx_frame;
  logic [3:0] tx_left, tx_rt, rx_rt;
  logic rx_pin, rx_par, rx_stop_bad, bit_val, rx_bit_end, rx_done, rx_load;
  logic stop_bad_now, par_bad;
  logic [1:0] rx_ones;
  logic [2:0] rx_idx;

  ast_pin_sync u_rx_sync (
    .clk(clk),
    .reset_n(reset_n),
    .pin(serial_in_pin),
    .level(rx_pin)
  );
  // Bus decode; an access completes at the edge where waitrequest is low
  assign req = read | write;
  assign bus_take = req & ~waitrequest;
  assign wr_ctrl_one = bus_take & write & byteenable[0] & (address == OFS_CTRL_ONE);
  assign wr_ctrl_two = bus_take & write & byteenable[0] & (address == OFS_CTRL_TWO);
  assign wr_data = bus_take & write & byteenable[0] & (address == OFS_DATA);
  assign rd_status = bus_take & read & (address == OFS_STATUS);
  assign rd_data = bus_take & read & (address == OFS_DATA);
  // Status word as software sees it
  always_comb begin
    status_view = '0;
    status_view.parity_error_flag = parity_error_flag;
    status_view.framing_error_flag = framing_error_flag;
    status_view.overrun_flag = overrun_flag;
    status_view.rx_buffer_full_flag = rx_buffer_full_flag;
    status_view.tx_done_flag = tx_done_flag;
    status_view.tx_buffer_empty_flag = tx_buffer_empty_flag;
  end
  // Read mux; unmapped addresses read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (address)
      OFS_CTRL_ONE: rd_mux = {24'h00_0000, ctrl};
      OFS_CTRL_TWO: rd_mux = {31'h0000_0000, rx_stop_length};
      OFS_STATUS: rd_mux = {24'h00_0000, status_view};
      OFS_DATA: rd_mux = {24'h00_0000, rx_data_buffer};
      default: rd_mux = 32'h0000_0000;
    endcase
  end
  // One wait cycle per access
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
    end else if (bus_take) begin
      waitrequest <= 1'b1;
    end else if (req) begin
      waitrequest <= 1'b0;
    end
  end
  // Read data captured during the wait cycle, held through the answer edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
    end else if (req && waitrequest) begin
      readdata <= read ? rd_mux : 32'h0000_0000;
    end
  end
  // Control registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= CTRL_ONE_RESET;
      rx_stop_length <= 1'b0;
    end else begin
      if (wr_ctrl_one) begin
        ctrl <= writedata[7:0];
      end
      if (wr_ctrl_two) begin
        rx_stop_length <= writedata[0];
      end
    end
  end
  // Status-read arming for the two clear sequences
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_armed <= 1'b0;
      rx_armed <= 1'b0;
      ovr_seen <= 1'b0;
    end else begin
      if (rd_status) begin
        tx_armed <= 1'b1;
        rx_armed <= 1'b1;
        ovr_seen <= overrun_flag; // RULE14
      end else begin
        if (wr_data) begin
          tx_armed <= 1'b0;
        end
        if (rd_data) begin
          rx_armed <= 1'b0;
          ovr_seen <= 1'b0;
        end
      end
    end
  end

  assign tx_wr_ok = wr_data & tx_armed & tx_buffer_empty_flag & ctrl.tx_enable_bit; // RULE1 RULE6
  assign rx_clear = rd_data & rx_armed; // RULE12
  // Receiver clock select
  always_comb begin
    unique case (ctrl.baud_select) // RULE18
      3'h0: div_max = DIV_SEL0;
      3'h1: div_max = DIV_SEL1;
      3'h2: div_max = DIV_SEL2;
      3'h3: div_max = DIV_SEL3;
      3'h4: div_max = DIV_SEL4;
      3'h5: div_max = DIV_SEL5;
      3'h6: div_max = DIV_SEL7;
      3'h7: div_max = DIV_SEL7;
    endcase
  end
  // Sample tick generator shared by both directions
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      baud_cnt <= 9'h000;
    end else if (baud_cnt >= div_max - 9'h001) begin
      baud_cnt <= 9'h000;
    end else begin
      baud_cnt <= baud_cnt + 9'h001;
    end
  end

  assign rt_tick = (ctrl.baud_select == BAUD_TIMER) ? timer_tick : // RULE17 RULE18
                   (baud_cnt == div_max - 9'h001);

  // Transmit control terms
  assign tx_load = ~tx_busy & tx_pending & ctrl.tx_enable_bit;
  assign tx_bit_end = tx_busy & rt_tick & (tx_rt == RT_LAST); // RULE19
  assign tx_last = tx_bit_end & (tx_left == 4'h1);
  assign tx_par = (^tx_hold) ^ ~ctrl.parity_even_bit; // RULE16
  // Transmit buffer and its flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_hold <= 8'h00;
      tx_pending <= 1'b0;
      tx_buffer_empty_flag <= STATUS_RESET[2];
      tx_done_flag <= STATUS_RESET[3];
    end else begin
      if (tx_wr_ok) begin
        tx_hold <= writedata[7:0];
        tx_pending <= 1'b1;
        tx_buffer_empty_flag <= 1'b0; // RULE2
      end
      if (tx_load) begin
        tx_pending <= 1'b0;
        tx_buffer_empty_flag <= 1'b1; // RULE4
        tx_done_flag <= 1'b0; // RULE15
      end else if (tx_last && !tx_pending) begin
        tx_done_flag <= 1'b1; // RULE15
      end
    end
  end
  // Transmit shifter; pin idles high and finishes a frame even if disabled
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy <= 1'b0;
      tx_frame <= 12'hfff;
      tx_left <= 4'h0;
      tx_rt <= 4'h0;
      serial_out_pin <= 1'b1; // RULE5
    end else if (tx_load) begin
      tx_busy <= 1'b1;
      tx_frame <= {2'b11, ctrl.parity_enable_bit ? tx_par : 1'b1, tx_hold, 1'b0}; // RULE3
      tx_left <= FRAME_BASE_BITS + {3'h0, ctrl.parity_enable_bit} +
                 {3'h0, ctrl.tx_stop_length}; // RULE3
      tx_rt <= 4'h0;
      serial_out_pin <= 1'b0;
    end else if (tx_busy && rt_tick) begin
      tx_rt <= tx_rt + 4'h1;
      if (tx_bit_end) begin
        tx_frame <= {1'b1, tx_frame[11:1]}; // RULE21
        tx_left <= tx_left - 4'h1;
        serial_out_pin <= tx_last ? 1'b1 : tx_frame[1];
        if (tx_last) begin
          tx_busy <= 1'b0;
        end
      end
    end
  end
  // Receive terms: majority of the three mid-bit samples
  assign bit_val = rx_ones[1]; // RULE20
  assign rx_bit_end = (rx_state != RX_IDLE) & rt_tick & (rx_rt == RT_LAST);
  assign rx_done = rx_bit_end & (((rx_state == RX_STOP_ONE) & ~rx_stop_length) |
                                 (rx_state == RX_STOP_TWO));
  assign stop_bad_now = rx_stop_bad | ~bit_val; // RULE11
  assign par_bad = ctrl.parity_enable_bit & ((^{rx_shift, rx_par}) ^ ~ctrl.parity_even_bit); // RULE10
  assign rx_load = rx_done & (~rx_buffer_full_flag | rx_clear);
  // Receive sequencer; enable and overrun only gate a new start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= RX_IDLE;
      rx_rt <= 4'h0;
      rx_ones <= 2'h0;
      rx_idx <= 3'h0;
      rx_shift <= 8'h00;
      rx_par <= 1'b0;
      rx_stop_bad <= 1'b0;
    end else if (rx_state == RX_IDLE) begin
      if (rt_tick && !rx_pin && ctrl.rx_enable_bit && !overrun_flag) begin // RULE9 RULE13
        rx_state <= RX_START;
        rx_rt <= 4'h1; // Detection tick is tick zero, so the next one is one
        rx_ones <= 2'h0;
      end
    end else if (rt_tick) begin
      rx_rt <= rx_rt + 4'h1;
      if (rx_rt >= RT_SAMPLE_FIRST && rx_rt <= RT_SAMPLE_LAST && rx_pin) begin
        rx_ones <= rx_ones + 2'h1; // RULE20
      end
      if (rx_rt == RT_LAST) begin
        rx_ones <= 2'h0;
        unique case (rx_state)
          RX_START: begin
            rx_state <= bit_val ? RX_IDLE : RX_DATA;
            rx_idx <= 3'h0;
            rx_stop_bad <= 1'b0;
          end
          RX_DATA: begin
            rx_shift <= {bit_val, rx_shift[7:1]}; // RULE21
            rx_idx <= rx_idx + 3'h1;
            if (rx_idx == DATA_LAST_IDX) begin
              rx_state <= ctrl.parity_enable_bit ? RX_PARITY : RX_STOP_ONE; // RULE16
            end
          end
          RX_PARITY: begin
            rx_par <= bit_val;
            rx_state <= RX_STOP_ONE;
          end
          RX_STOP_ONE: begin
            rx_stop_bad <= ~bit_val;
            rx_state <= rx_stop_length ? RX_STOP_TWO : RX_IDLE;
          end
          RX_STOP_TWO: rx_state <= RX_IDLE;
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end
  // Receive buffer and flags; a new event wins over a same-cycle clear
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_data_buffer <= 8'h00;
      rx_buffer_full_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      framing_error_flag <= 1'b0;
      overrun_flag <= 1'b0;
    end else begin
      if (rx_clear) begin
        rx_buffer_full_flag <= 1'b0; // RULE12
        parity_error_flag <= 1'b0;
        framing_error_flag <= 1'b0;
        if (ovr_seen) begin
          overrun_flag <= 1'b0; // RULE14
        end
      end
      if (rx_load) begin
        rx_data_buffer <= rx_shift; // RULE7
        rx_buffer_full_flag <= 1'b1;
        parity_error_flag <= par_bad; // RULE10
        framing_error_flag <= stop_bad_now; // RULE11
      end else if (rx_done) begin
        overrun_flag <= 1'b1; // RULE8
      end
    end
  end
  // Shared interrupt pulse
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_txrx_irq <= 1'b0;
    end else begin
      serial_txrx_irq <= tx_load | rx_load; // RULE4 RULE7
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence s_tx_frame_start;
    tx_load ##1 (tx_buffer_empty_flag && serial_txrx_irq && !serial_out_pin && !tx_done_flag);
  endsequence

  sequence s_rx_stored;
    rx_load ##1 (rx_buffer_full_flag && serial_txrx_irq);
  endsequence

  a_tx_start_flags: assert property (tx_load |-> s_tx_frame_start) // RULE4
    else $error("transmit start flags wrong");
  a_tx_write_clear: assert property (tx_wr_ok |=> !tx_buffer_empty_flag && tx_pending) // RULE2
    else $error("data write did not clear buffer empty");
  a_tx_unread_write: assert property ((wr_data && !tx_armed && tx_buffer_empty_flag) // RULE6
    |=> tx_buffer_empty_flag && !tx_pending) else $error("unarmed write was accepted");
  a_tx_idle_high: assert property (!tx_busy |-> serial_out_pin) // RULE5
    else $error("transmit pin low while idle");
  a_tx_end_flag: assert property ((tx_last && !tx_pending) // RULE15
    |=> tx_done_flag && serial_out_pin) else $error("transmit end flag not set");
  a_rx_store_data: assert property (rx_load |-> s_rx_stored) // RULE7
    else $error("receive buffer not loaded");
  a_rx_overrun_keep: assert property ((rx_done && rx_buffer_full_flag && !rx_clear) // RULE8
    |=> overrun_flag && $stable(rx_data_buffer)) else $error("overrun handling wrong");
  a_rx_parity_err: assert property ((rx_load && par_bad) |=> parity_error_flag) // RULE10
    else $error("parity error not flagged");
  a_rx_frame_err: assert property ((rx_load && stop_bad_now) |=> framing_error_flag) // RULE11
    else $error("framing error not flagged");
  a_rx_clear_seq: assert property ((rx_clear && !rx_done) // RULE12
    |=> !rx_buffer_full_flag && !parity_error_flag && !framing_error_flag)
    else $error("receive flags not cleared");
  a_ovr_late_keep: assert property ((rx_clear && !ovr_seen && overrun_flag) |=> overrun_flag) // RULE14
    else $error("late overrun was cleared");
  a_ovr_blocks_rx: assert property ((overrun_flag && rx_state == RX_IDLE) // RULE13
    |=> rx_state == RX_IDLE) else $error("reception started during overrun");
  a_bus_answer: assert property ((req && waitrequest) |=> !waitrequest)
    else $error("bus answer late");
endmodule
`default_nettype wire

/* testbench/ast_peer.sv */
`timescale 1ns/1ps
`default_nettype none
// Remote serial peer: frames bytes toward the block and decodes what it sends
module ast_peer (
  input wire logic clk,
  input wire logic from_dut,
  output logic to_dut
);
  int bit_clks = 208;
  int stops = 1;
  logic par_en = 1'b1;
  logic even = 1'b1;
  logic [7:0] got = 8'h00;
  logic got_par = 1'b0;
  int got_stop_low = 0;
  int n_frames = 0;

  // Line idles high between frames
  initial begin
    to_dut = 1'b1;
  end

  task automatic wait_clks(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Send one frame, optionally with a wrong parity bit or a low stop bit
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    @(posedge clk);
    to_dut <= 1'b0;
    wait_clks(bit_clks);
    for (int i = 0; i < 8; i++) begin
      to_dut <= d[i];
      wait_clks(bit_clks);
    end
    if (par_en) begin
      to_dut <= (even ? ^d : ~^d) ^ bad_par;
      wait_clks(bit_clks);
    end
    to_dut <= ~bad_stop;
    wait_clks(bit_clks * stops);
    to_dut <= 1'b1;
    wait_clks(bit_clks * 2);
  endtask

  // Decode frames leaving the block by sampling each bit in its middle
  always begin
    @(negedge from_dut);
    wait_clks(bit_clks / 2);
    for (int i = 0; i < 8; i++) begin
      wait_clks(bit_clks);
      got[i] = from_dut;
    end
    if (par_en) begin
      wait_clks(bit_clks);
      got_par = from_dut;
    end
    got_stop_low = 0;
    repeat (stops) begin
      wait_clks(bit_clks);
      if (from_dut !== 1'b1) got_stop_low++;
    end
    n_frames++;
  end
endmodule
`default_nettype wire

/* testbench/async_serial_txrx_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module async_serial_txrx_status_tb;
  import ast_pkg::*;
  logic clk;
  logic reset_n;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [DATA_W-1:0] writedata;
  logic [DATA_W-1:0] readdata;
  logic waitrequest;
  logic timer_tick = 1'b0;
  logic rx_line;
  logic serial_out_pin;
  logic serial_txrx_irq;
  logic [DATA_W-1:0] rd;
  int fail_count = 0;
  int n_tests = 0;
  int irq_n = 0;
  int tick_cnt = 0;
  logic [3:0] byteenable = 4'h1;
  logic [7:0] tx_cfg [4] = '{8'hd8, 8'ha9, 8'h8e, 8'h87};
  int tx_bit [4] = '{208, 416, 208, 1536};
  logic [7:0] tx_dat [4] = '{8'ha5, 8'h3c, 8'hc3, 8'h5e};
  logic [7:0] rx_dat [3] = '{8'h5a, 8'h33, 8'h81};
  logic [1:0] rx_bad [3] = '{2'h0, 2'h1, 2'h2};
  logic [7:0] rx_st [3] = '{8'h1c, 8'h9c, 8'h5c};

  ast_uart dut (
    .clk(clk),
    .reset_n(reset_n),
    .address(address),
    .read(read),
    .write(write),
    .writedata(writedata),
    .byteenable(byteenable),
    .readdata(readdata),
    .waitrequest(waitrequest),
    .timer_tick(timer_tick),
    .serial_in_pin(rx_line),
    .serial_out_pin(serial_out_pin),
    .serial_txrx_irq(serial_txrx_irq)
  );

  ast_peer peer (
    .clk(clk),
    .from_dut(serial_out_pin),
    .to_dut(rx_line)
  );

  // Free-running clock, 8 ns period
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Timer pulse every 13 cycles; count interrupt pulses
  always @(posedge clk) begin
    tick_cnt <= (tick_cnt == 12) ? 0 : tick_cnt + 1;
    timer_tick <= (tick_cnt == 12);
    if (serial_txrx_irq === 1'b1) irq_n <= irq_n + 1;
  end

  task automatic chk(input string name, input logic [DATA_W-1:0] exp,
                     input logic [DATA_W-1:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus_access(input logic [ADDR_W-1:0] a, input logic wr,
                            input logic [DATA_W-1:0] d);
    int n;
    @(posedge clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 100);
    rd = readdata;
    if (n >= 100) begin
      fail_count++;
      $display("mismatch waitrequest expected %h seen %h", 1'b0, waitrequest);
    end
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    bus_access(a, 1'b1, {24'h0, d});
  endtask

  task automatic rd_reg(input logic [ADDR_W-1:0] a);
    bus_access(a, 1'b0, '0);
  endtask

  task automatic wait_tx(input int old);
    int k;
    k = 0;
    while (peer.n_frames == old && k < 20000) begin
      @(posedge clk);
      k++;
    end
    if (k >= 20000) begin
      fail_count++;
      $display("mismatch frame count expected %0d seen %0d", old + 1, peer.n_frames);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Cut a hang short
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    int old;
    int i0;
    reset_n = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    // Data write with no status read before it must not send
    wr_reg(OFS_CTRL_ONE, 8'hd8);
    wr_reg(OFS_DATA, 8'h77);
    repeat (3000) @(posedge clk);
    chk("frames", 32'h0, peer.n_frames);
    chk("idle pin", 32'h1, serial_out_pin);
    rd_reg(5'h10);
    chk("unmapped", 32'h0, rd);
    rd_reg(OFS_STATUS);
    chk("status", 32'h0c, rd);
    // Transmit at two dividers, on the timer tick, and at divide by 96 without parity
    for (int c = 0; c < 4; c++) begin
      peer.bit_clks = tx_bit[c];
      peer.par_en = tx_cfg[c][3];
      peer.even = tx_cfg[c][4];
      peer.stops = tx_cfg[c][5] ? 2 : 1;
      wr_reg(OFS_CTRL_ONE, tx_cfg[c]);
      old = peer.n_frames;
      i0 = irq_n;
      rd_reg(OFS_STATUS);
      chk("status before send", 32'h0c, rd);
      wr_reg(OFS_DATA, tx_dat[c]);
      repeat (4) @(posedge clk);
      rd_reg(OFS_STATUS);
      chk("status in frame", 32'h04, rd);
      chk("irq on start", i0 + 1, irq_n);
      wait_tx(old);
      chk("sent byte", tx_dat[c], peer.got);
      if (tx_cfg[c][3]) begin
        chk("sent parity", tx_cfg[c][4] ? ^tx_dat[c] : ~^tx_dat[c], peer.got_par);
      end
      chk("stop bits", 32'h0, peer.got_stop_low);
      repeat (tx_bit[c]) @(posedge clk);
      rd_reg(OFS_STATUS);
      chk("status after send", 32'h0c, rd);
    end
    // Receive good, bad parity and bad stop frames
    wr_reg(OFS_CTRL_ONE, 8'hd8);
    peer.bit_clks = 208;
    peer.par_en = 1'b1;
    peer.even = 1'b1;
    peer.stops = 1;
    for (int k = 0; k < 3; k++) begin
      i0 = irq_n;
      peer.send(rx_dat[k], rx_bad[k][0], rx_bad[k][1]);
      chk("irq on load", i0 + 1, irq_n);
      rd_reg(OFS_STATUS);
      chk("rx status", rx_st[k], rd);
      rd_reg(OFS_DATA);
      chk("rx data", rx_dat[k], rd);
      rd_reg(OFS_STATUS);
      chk("status cleared", 32'h0c, rd);
    end
    // Overrun keeps the old byte and blocks reception until cleared
    peer.send(8'h11, 1'b0, 1'b0);
    peer.send(8'h22, 1'b0, 1'b0);
    rd_reg(OFS_STATUS);
    chk("overrun status", 32'h3c, rd);
    peer.send(8'h44, 1'b0, 1'b0);
    rd_reg(OFS_DATA);
    chk("kept data", 32'h11, rd);
    rd_reg(OFS_STATUS);
    chk("overrun cleared", 32'h0c, rd);
    // Overrun arising after the status read survives the data read
    peer.send(8'h66, 1'b0, 1'b0);
    rd_reg(OFS_STATUS);
    chk("full status", 32'h1c, rd);
    peer.send(8'h77, 1'b0, 1'b0);
    rd_reg(OFS_DATA);
    chk("late overrun data", 32'h66, rd);
    rd_reg(OFS_STATUS);
    chk("late overrun kept", 32'h2c, rd);
    rd_reg(OFS_DATA);
    rd_reg(OFS_STATUS);
    chk("final status", 32'h0c, rd);
    // Two receive stop bits, both low; a write without byte lane 0 is ignored
    wr_reg(OFS_CTRL_TWO, 8'h01);
    byteenable <= 4'h0;
    wr_reg(OFS_CTRL_TWO, 8'h00);
    byteenable <= 4'h1;
    rd_reg(OFS_CTRL_TWO);
    chk("ctrl two", 32'h1, rd);
    peer.stops = 2;
    i0 = irq_n;
    peer.send(8'h99, 1'b0, 1'b1);
    chk("irq two stops", i0 + 1, irq_n);
    rd_reg(OFS_STATUS);
    chk("two stop status", 32'h5c, rd);
    rd_reg(OFS_DATA);
    chk("two stop data", 32'h99, rd);
    rd_reg(OFS_STATUS);
    chk("two stop cleared", 32'h0c, rd);
    print_verdict();
  end
endmodule
`default_nettype wire
